// ---- rtl/exec_pkg.sv ----
// Notes on behaviour
// - Increment adds one to file register; result to accumulator or file; zero flag updated.
// - File addresses are 7 bits (0..127); result target is a single bit.
// - OR of accumulator and file register goes to selected target; zero flag updated.
// - Copy moves file value to accumulator or back to itself; zero flag updated.
// - Copy onto itself keeps the value but still sets or clears zero flag.
// - Return from interrupt loads counter from stack top and sets global interrupt allow.
// - Load literal puts 8-bit literal into accumulator; no flag changes.
// - Return with literal puts literal into accumulator; flags untouched.
// - Return with literal reloads counter from stack top and takes two cycles.
// - Store accumulator writes accumulator into the addressed file register; no flag changes.
// - Every return pops the stack after copying its top into the counter.
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic ZERO_FLAG_RESET = 1'b0;
  localparam logic IRQ_ALLOW_RESET = 1'b0;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INCREMENT_FILE = 3'b001,
    OP_OR_ACCUM_WITH_FILE = 3'b010,
    OP_COPY_FILE = 3'b011,
    OP_STORE_ACCUM_TO_FILE = 3'b100,
    OP_LOAD_LITERAL_ACCUM = 3'b101,
    OP_RETURN_WITH_LITERAL = 3'b110,
    OP_RETURN_FROM_IRQ = 3'b111
  } op_t;

  typedef struct packed {
    op_t op;
    logic [FADDR_W-1:0] faddr;
    logic result_target;
    logic [DATA_W-1:0] literal;
  } instr_t;

  typedef struct packed {
    logic file_we;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] data;
  } file_wr_t;
endpackage : exec_pkg

// ---- rtl/alu_calc.sv ----
`timescale 1ns/1ps
module alu_calc
  import exec_pkg::*;
(
  input wire op_t op,
  input wire logic [DATA_W-1:0] accum,
  input wire logic [DATA_W-1:0] fval,
  input wire logic [DATA_W-1:0] literal,
  output logic [DATA_W-1:0] result,
  output logic touches_zero
);
  always_comb begin
    result = ZERO;
    touches_zero = 1'b0;
    unique case (op)
      OP_INCREMENT_FILE: begin
        // Carry-out is dropped on purpose so 255 wraps to 0 silently.
        result = fval + ONE;
        touches_zero = 1'b1;
      end
      OP_OR_ACCUM_WITH_FILE: begin
        result = accum | fval;
        touches_zero = 1'b1;
      end
      OP_COPY_FILE: begin
        result = fval;
        touches_zero = 1'b1;
      end
      OP_STORE_ACCUM_TO_FILE: result = accum;
      OP_LOAD_LITERAL_ACCUM: result = literal;
      OP_RETURN_WITH_LITERAL: result = literal;
      OP_RETURN_FROM_IRQ: result = accum;
      OP_NONE: result = accum;
    endcase
  end
endmodule : alu_calc

// ---- rtl/move_incr_or_return_exec.sv ----
`timescale 1ns/1ps
module move_incr_or_return_exec
  import exec_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic INSTR_VALID,
  input wire instr_t INSTR,
  output logic INSTR_READY,
  input wire logic [DATA_W-1:0] FILE_RDATA,
  output logic [FADDR_W-1:0] FILE_RADDR,
  output file_wr_t FILE_WR,
  input wire logic [PC_W-1:0] STACK_TOP_ENTRY,
  output logic STACK_POP,
  output logic [DATA_W-1:0] ACCUM,
  output logic ZERO_FLAG,
  output logic GLOBAL_IRQ_ALLOW,
  output logic [PC_W-1:0] PROGRAM_COUNTER,
  output logic PC_LOAD,
  output logic DONE
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_SECOND = 1'b1
  } state_t;

  state_t state_reg, state_next;
  logic [DATA_W-1:0] accum_reg, accum_next;
  logic zero_reg, zero_next;
  logic irq_allow_reg, irq_allow_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic pc_load_reg, pc_load_next;
  logic pop_reg, pop_next;
  logic done_reg, done_next;
  file_wr_t fwr_reg, fwr_next;
  logic [DATA_W-1:0] result;
  logic touches_zero;
  logic take;
  logic is_reg_op;
  logic is_store;
  logic is_load;
  logic is_ret_lit;
  logic is_ret_irq;
  logic is_return;
  logic to_file;
  logic result_zero;

  // The file read is combinational, so FILE_RDATA must return the addressed byte in the same cycle.
  assign FILE_RADDR = INSTR.faddr;
  assign INSTR_READY = (state_reg == ST_EXEC);
  assign take = INSTR_VALID && INSTR_READY;

  alu_calc u_alu (
    .op(INSTR.op),
    .accum(accum_reg),
    .fval(FILE_RDATA),
    .literal(INSTR.literal),
    .result(result),
    .touches_zero(touches_zero)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode once here so each state group below reads plain qualifiers.
  always_comb begin
    is_reg_op = 1'b0;
    is_store = 1'b0;
    is_load = 1'b0;
    is_ret_lit = 1'b0;
    is_ret_irq = 1'b0;
    unique case (INSTR.op)
      OP_INCREMENT_FILE, OP_OR_ACCUM_WITH_FILE, OP_COPY_FILE: is_reg_op = 1'b1;
      OP_STORE_ACCUM_TO_FILE: is_store = 1'b1;
      OP_LOAD_LITERAL_ACCUM: is_load = 1'b1;
      OP_RETURN_WITH_LITERAL: is_ret_lit = 1'b1;
      OP_RETURN_FROM_IRQ: is_ret_irq = 1'b1;
      OP_NONE: begin
      end
    endcase
  end

  assign is_return = is_ret_lit || is_ret_irq;
  assign to_file = is_store || (is_reg_op && INSTR.result_target);
  assign result_zero = (result == ZERO);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing. A return holds off the next instruction for one cycle, so a stale prefetch is never taken.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_EXEC: begin
        if (take && is_return) begin
          state_next = ST_SECOND;
        end
      end
      ST_SECOND: begin
        // The second cycle stands in for the discarded prefetch after the redirect.
        state_next = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion and stack pulses, each high for exactly one cycle.
  always_comb begin
    done_next = 1'b0;
    pop_next = 1'b0;
    pc_load_next = 1'b0;
    unique case (state_reg)
      ST_EXEC: begin
        if (take && is_return) begin
          pop_next = 1'b1;
          pc_load_next = 1'b1;
        end else if (take) begin
          done_next = 1'b1;
        end
      end
      ST_SECOND: begin
        done_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      done_reg <= 1'b0;
      pop_reg <= 1'b0;
      pc_load_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      pop_reg <= pop_next;
      pc_load_reg <= pc_load_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Accumulator and zero flag. Only the file-register ops touch the flag; no carry is produced here.
  always_comb begin
    accum_next = accum_reg;
    zero_next = zero_reg;
    if (take) begin
      if (touches_zero) begin
        zero_next = result_zero;
      end
      if (is_load || is_ret_lit) begin
        accum_next = result;
      end else if (is_reg_op && !INSTR.result_target) begin
        accum_next = result;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      accum_reg <= ACCUM_RESET;
      zero_reg <= ZERO_FLAG_RESET;
    end else begin
      accum_reg <= accum_next;
      zero_reg <= zero_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program counter and interrupt allow. The allow bit is only set here; clearing it belongs elsewhere.
  always_comb begin
    pc_next = pc_reg;
    irq_allow_next = irq_allow_reg;
    if (take && is_return) begin
      pc_next = STACK_TOP_ENTRY;
    end
    if (take && is_ret_irq) begin
      irq_allow_next = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pc_reg <= PC_RESET;
      irq_allow_reg <= IRQ_ALLOW_RESET;
    end else begin
      pc_reg <= pc_next;
      irq_allow_reg <= irq_allow_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // File write port. The strobe lasts one cycle; address and data ride with it.
  always_comb begin
    fwr_next = '0;
    if (take && to_file) begin
      fwr_next.file_we = 1'b1;
      fwr_next.faddr = INSTR.faddr;
      fwr_next.data = result;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      fwr_reg <= '0;
    end else begin
      fwr_reg <= fwr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every output except FILE_RADDR and INSTR_READY comes straight from a flip-flop, so the core sees it settled early in the cycle.
  assign ACCUM = accum_reg;
  assign ZERO_FLAG = zero_reg;
  assign GLOBAL_IRQ_ALLOW = irq_allow_reg;
  assign PROGRAM_COUNTER = pc_reg;
  assign PC_LOAD = pc_load_reg;
  assign STACK_POP = pop_reg;
  assign DONE = done_reg;
  assign FILE_WR = fwr_reg;
endmodule : move_incr_or_return_exec

// ---- bench/move_incr_or_return_exec_properties.sv ----
`timescale 1ns/1ps
module exec_props
  import exec_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic INSTR_VALID,
  input wire instr_t INSTR,
  input wire logic INSTR_READY,
  input wire logic [DATA_W-1:0] FILE_RDATA,
  input wire file_wr_t FILE_WR,
  input wire logic [PC_W-1:0] STACK_TOP_ENTRY,
  input wire logic STACK_POP,
  input wire logic [DATA_W-1:0] ACCUM,
  input wire logic ZERO_FLAG,
  input wire logic GLOBAL_IRQ_ALLOW,
  input wire logic [PC_W-1:0] PROGRAM_COUNTER,
  input wire logic PC_LOAD,
  input wire logic DONE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  logic tk;
  logic ret;
  op_t o;
  assign tk = INSTR_VALID && INSTR_READY;
  assign o = INSTR.op;
  assign ret = o inside {OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_IRQ};
  property p_rl;
    tk && o == OP_RETURN_WITH_LITERAL |=> ACCUM == $past(INSTR.literal) && $stable(ZERO_FLAG);
  endproperty
  a_rl: assert property (p_rl) else $error("literal return wrong");
  property p_ri;
    tk && ret |=> GLOBAL_IRQ_ALLOW == ($past(GLOBAL_IRQ_ALLOW) | $past(o[0]))
      && PROGRAM_COUNTER == $past(STACK_TOP_ENTRY);
  endproperty
  a_ri: assert property (p_ri) else $error("return wrong");
  property p_pop; tk && ret |=> STACK_POP && PC_LOAD && !INSTR_READY && !DONE ##1 DONE && !STACK_POP; endproperty
  a_pop: assert property (p_pop) else $error("return timing wrong");
  property p_one; tk && !ret |=> DONE && !STACK_POP; endproperty
  a_one: assert property (p_one) else $error("single cycle wrong");
  property p_st;
    tk && o == OP_STORE_ACCUM_TO_FILE |=> FILE_WR.file_we && FILE_WR.data == $past(ACCUM) && $stable(ZERO_FLAG);
  endproperty
  a_st: assert property (p_st) else $error("store wrong");
  property p_inc; tk && o == OP_INCREMENT_FILE |=> ZERO_FLAG == ($past(FILE_RDATA) == 8'hFF); endproperty
  a_inc: assert property (p_inc) else $error("increment zero wrong");
  property p_cp;
    tk && o == OP_COPY_FILE && INSTR.result_target |=> FILE_WR.file_we && FILE_WR.data == $past(FILE_RDATA)
      && ZERO_FLAG == ($past(FILE_RDATA) == 8'h00);
  endproperty
  a_cp: assert property (p_cp) else $error("copy self wrong");
  property p_or;
    tk && o == OP_OR_ACCUM_WITH_FILE && !INSTR.result_target |=> ACCUM == ($past(ACCUM) | $past(FILE_RDATA));
  endproperty
  a_or: assert property (p_or) else $error("or wrong");
endmodule : exec_props

// ---- bench/tb_move_incr_or_return_exec.sv ----
`timescale 1ns/1ps
module tb_move_incr_or_return_exec import exec_pkg::*; ;
  logic REF_CLK = 0, SRST = 1, INSTR_VALID = 0, INSTR_READY, STACK_POP, ZERO_FLAG, GLOBAL_IRQ_ALLOW, PC_LOAD, DONE;
  instr_t INSTR = '0;
  logic [7:0] FILE_RDATA = 8'h00, ACCUM;
  logic [12:0] STACK_TOP_ENTRY = 13'h0000, PROGRAM_COUNTER;
  logic [6:0] FILE_RADDR;
  file_wr_t FILE_WR;
  int num_errors = 0, n_compared = 0, cyc = 0;
  typedef struct {op_t op; logic rt; logic [7:0] lit, rd, acc; logic z, we; logic [7:0] wd;} row_t;
  row_t rows [11] = '{'{OP_LOAD_LITERAL_ACCUM, 0, 8'h5A, 0, 8'h5A, 0, 0, 0},
    '{OP_OR_ACCUM_WITH_FILE, 0, 0, 8'h81, 8'hDB, 0, 0, 0}, '{OP_INCREMENT_FILE, 0, 0, 8'h41, 8'h42, 0, 0, 0},
    '{OP_OR_ACCUM_WITH_FILE, 1, 0, 8'h00, 8'h42, 0, 1, 8'h42}, '{OP_INCREMENT_FILE, 1, 0, 8'hFF, 8'h42, 1, 1, 8'h00},
    '{OP_STORE_ACCUM_TO_FILE, 0, 0, 0, 8'h42, 1, 1, 8'h42}, '{OP_COPY_FILE, 0, 0, 8'h00, 8'h00, 1, 0, 0},
    '{OP_COPY_FILE, 1, 0, 8'h80, 8'h00, 0, 1, 8'h80}, '{OP_LOAD_LITERAL_ACCUM, 0, 8'hFF, 0, 8'hFF, 0, 0, 0},
    '{OP_COPY_FILE, 1, 0, 8'h00, 8'hFF, 1, 1, 8'h00}, '{OP_NONE, 0, 8'h33, 8'h00, 8'hFF, 1, 0, 0}};
  always #2.5 REF_CLK = ~REF_CLK;
  move_incr_or_return_exec dut_u (.*);
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task issue(input op_t op, input logic rt, input logic [7:0] lit, input logic [7:0] rd, input logic [12:0] top,
             input logic [6:0] fa);
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b1;
    INSTR <= '{op, fa, rt, lit};
    FILE_RDATA <= rd;
    STACK_TOP_ENTRY <= top;
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b0;
    FILE_RDATA <= ~rd;
    #1;
  endtask : issue
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // The ceiling is more than ten times the expected run of about forty-five cycles.
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc > 500) begin
      num_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge REF_CLK);
    SRST <= 1'b0;
    #1 chk("irq_allow", 0, GLOBAL_IRQ_ALLOW);
    chk("ready", 1, INSTR_READY);
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].rt, rows[i].lit, rows[i].rd, 13'h1FFF, 7'h7F ^ 7'(i));
      chk("accum", rows[i].acc, ACCUM);
      chk("zero", rows[i].z, ZERO_FLAG);
      chk("done", 1, DONE);
      chk("raddr", 7'h7F ^ 7'(i), FILE_RADDR);
      if (rows[i].we) chk("wdata", rows[i].wd, FILE_WR.data);
      if (rows[i].we) chk("waddr", 7'h7F ^ 7'(i), FILE_WR.faddr);
      chk("we", rows[i].we, FILE_WR.file_we);
    end
    $display("table test done");
    issue(OP_RETURN_WITH_LITERAL, 0, 8'h3C, 0, 13'h0123, 7'h00);
    chk("accum", 8'h3C, ACCUM);
    chk("zero", 1, ZERO_FLAG);
    chk("pc", 13'h0123, PROGRAM_COUNTER);
    chk("pop", 1, STACK_POP & PC_LOAD & ~INSTR_READY);
    chk("done", 0, DONE);
    @(posedge REF_CLK);
    #1 chk("done", 1, DONE);
    chk("ready", 1, INSTR_READY);
    issue(OP_RETURN_FROM_IRQ, 0, 8'h00, 0, 13'h00AB, 7'h00);
    chk("irq_allow", 1, GLOBAL_IRQ_ALLOW);
    chk("pc", 13'h00AB, PROGRAM_COUNTER);
    chk("zero", 1, ZERO_FLAG);
    chk("pop", 1, STACK_POP & PC_LOAD & ~INSTR_READY);
    @(posedge REF_CLK);
    #1 chk("done", 1, DONE);
    @(posedge REF_CLK) SRST <= 1'b1;
    @(posedge REF_CLK) SRST <= 1'b0;
    #1 chk("irq_allow", 0, GLOBAL_IRQ_ALLOW);
    chk("accum", 0, ACCUM);
    chk("zero", 0, ZERO_FLAG);
    chk("pc", 0, PROGRAM_COUNTER);
    chk("ready", 1, INSTR_READY);
    issue(OP_LOAD_LITERAL_ACCUM, 0, 8'h11, 0, 13'h0000, 7'h01);
    chk("accum", 8'h11, ACCUM);
    chk("zero", 0, ZERO_FLAG);
    $display("return and reset test done");
    finish_test();
  end
endmodule : tb_move_incr_or_return_exec
bind move_incr_or_return_exec exec_props chk_u (.*);
